// ---- hw/sbsc_pkg.sv ----
// Constants and types for the synchronous burst SRAM cycle control
// Behaviour
// - Synchronous inputs sampled on rising clock edge
// - Strobe with a select inactive deselects; processor strobe is ignored while chip select is high
// - Processor strobe with all selects: begin read
// - Controller strobe: write if any lane, else read
// - No strobe, step low: advance and access
// - No strobe, step high: repeat current address
// - Write when any lane enable is low
// - Each lane enable writes its own byte
// - Processor strobe reads; write comes next edge
// - Deselect tristates data in the same cycle
// - Data outputs stay tristated until a read
// - Continue accesses next burst address
package sbsc_pkg;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int ADDR_W = 15;
    localparam int CNT_W = 2;
    localparam int BUF_DEPTH = 2;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [CNT_W-1:0] CNT_START = 2'h0;
    localparam logic [CNT_W-1:0] CNT_STEP = 2'h1;
    localparam logic [LANES-1:0] LANES_OFF = 4'hF;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        SBSC_DESELECT,
        SBSC_BEGIN_RD,
        SBSC_BEGIN_WR,
        SBSC_CONT,
        SBSC_SUSP
    } sbsc_cycle_t;
endpackage : sbsc_pkg

// ---- hw/sbsc_wbuf_if.sv ----
// Interface carrying the write buffer's fill, drain and entry view
`timescale 1ns/1ps
interface sbsc_wbuf_if #(parameter int W = 8);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    logic [1:0] ent_valid;
    logic [W-1:0] ent_data [2];

    modport buf_side (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data, ent_valid, ent_data
    );
    modport user_side (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data, ent_valid, ent_data
    );
endinterface : sbsc_wbuf_if

// ---- hw/sbsc_wbuf.sv ----
// Two-entry write buffer with valid and ready on both sides
`timescale 1ns/1ps
module sbsc_wbuf #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    sbsc_wbuf_if.buf_side bus
);
    import sbsc_pkg::*;

    logic [1:0] v_q;
    logic [1:0] v_d;
    logic [W-1:0] d_q [2];
    logic [W-1:0] d_d [2];
    logic push;
    logic pop;

    // Full buffer still accepts when the head drains this cycle
    assign bus.in_ready = !v_q[1] || bus.out_ready;
    assign bus.out_valid = v_q[0];
    assign bus.out_data = d_q[0];
    assign bus.ent_valid = v_q;
    assign bus.ent_data[0] = d_q[0];
    assign bus.ent_data[1] = d_q[1];

    always_comb
    begin
        v_d = v_q;
        d_d[0] = d_q[0];
        d_d[1] = d_q[1];
        push = bus.in_valid && bus.in_ready;
        pop = v_q[0] && bus.out_ready;
        if (pop)
        begin
            d_d[0] = d_q[1];
            v_d = {1'b0, v_q[1]};
        end
        if (push)
        begin
            if (!v_d[0])
            begin
                d_d[0] = bus.in_data;
                v_d[0] = 1'b1;
            end
            else
            begin
                d_d[1] = bus.in_data;
                v_d[1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            v_q <= 2'h0;
            d_q[0] <= '0;
            d_q[1] <= '0;
        end
        else
        begin
            v_q <= v_d;
            d_q[0] <= d_d[0];
            d_q[1] <= d_d[1];
        end
    end
endmodule : sbsc_wbuf

// ---- hw/sbsc_top.sv ----
// Cycle decode, burst counter, storage and data drive of the burst SRAM
`timescale 1ns/1ps
module sbsc_top #(
    parameter int AW = sbsc_pkg::ADDR_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [AW-1:0] addr,
    input wire logic chip_select_n,
    input wire logic second_select_hi,
    input wire logic second_select_n,
    input wire logic proc_addr_strobe_n,
    input wire logic ctrl_addr_strobe_n,
    input wire logic burst_step_n,
    input wire logic lane0_write_n,
    input wire logic lane1_write_n,
    input wire logic lane2_write_n,
    input wire logic lane3_write_n,
    input wire logic output_enable_n,
    input wire logic burst_order_sel,
    input wire logic pipeline_sel,
    input wire logic [sbsc_pkg::DATA_W-1:0] data_in,
    output logic [sbsc_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n
);
    import sbsc_pkg::*;

    localparam int ENT_W = AW + LANES + DATA_W;

    // ==========================================================
    // Cycle decode
    sbsc_cycle_t cyc;
    logic [LANES-1:0] lane_n;
    logic any_lane_write_n;
    logic all_sel;
    logic load;

    assign lane_n = {lane3_write_n, lane2_write_n, lane1_write_n,
                     lane0_write_n};
    assign any_lane_write_n = &lane_n;
    assign all_sel = !chip_select_n && !second_select_n && second_select_hi;
    assign load = !chip_select_n &&
                  (!proc_addr_strobe_n || !ctrl_addr_strobe_n);

    always_comb
    begin
        if (chip_select_n && !ctrl_addr_strobe_n)
            cyc = SBSC_DESELECT;
        else if (load && !all_sel)
            cyc = SBSC_DESELECT;
        else if (load && !proc_addr_strobe_n)
            cyc = SBSC_BEGIN_RD;
        else if (load)
            cyc = any_lane_write_n ? SBSC_BEGIN_RD : SBSC_BEGIN_WR;
        else if (!burst_step_n)
            cyc = SBSC_CONT;
        else
            cyc = SBSC_SUSP;
    end

    // ==========================================================
    // Burst counter
    logic [AW-1:0] base_q;
    logic [AW-1:0] base_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [AW-1:0] acc_addr;
    logic [CNT_W-1:0] lo;

    always_comb
    begin
        base_d = base_q;
        cnt_d = cnt_q;
        case (cyc)
            SBSC_BEGIN_RD, SBSC_BEGIN_WR:
            begin
                base_d = addr;
                cnt_d = CNT_START;
            end
            SBSC_CONT: cnt_d = cnt_q + CNT_STEP;
            SBSC_SUSP: cnt_d = cnt_q;
            default: cnt_d = cnt_q;
        endcase
        if (burst_order_sel)
            lo = base_d[CNT_W-1:0] ^ cnt_d;
        else
            lo = base_d[CNT_W-1:0] + cnt_d;
        acc_addr = {base_d[AW-1:CNT_W], lo};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            base_q <= '0;
            cnt_q <= CNT_START;
        end
        else
        begin
            base_q <= base_d;
            cnt_q <= cnt_d;
        end
    end

    // ==========================================================
    // Write buffer and storage
    logic wr_now;
    logic rd_now;
    logic [LANES-1:0] wr_mask;
    logic [DATA_W-1:0] mem [2**AW];
    logic [AW-1:0] dr_addr;
    logic [LANES-1:0] dr_mask;

    // processor start never writes; relies on the next continue or suspend
    assign wr_now = (cyc == SBSC_BEGIN_WR) ||
                    ((cyc == SBSC_CONT || cyc == SBSC_SUSP) &&
                     !any_lane_write_n);
    assign rd_now = (cyc != SBSC_DESELECT) && !wr_now;
    assign wr_mask = ~lane_n;

    sbsc_wbuf_if #(.W(ENT_W)) wb ();

    assign wb.in_valid = wr_now;
    assign wb.in_data = {acc_addr, wr_mask, data_in};
    // Single port: reads take the array, writes drain otherwise
    assign wb.out_ready = !rd_now;
    assign dr_addr = wb.out_data[ENT_W-1 -: AW];
    assign dr_mask = wb.out_data[DATA_W +: LANES];

    sbsc_wbuf #(.W(ENT_W)) u_wbuf (
        .clk(clk),
        .resetn(resetn),
        .bus(wb.buf_side)
    );

    // Storage has no reset, like the array it models
    always_ff @(posedge clk)
    begin
        if (wb.out_valid && wb.out_ready)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (dr_mask[i])
                    mem[dr_addr][i*LANE_W +: LANE_W] <=
                        wb.out_data[i*LANE_W +: LANE_W];
            end
        end
    end

    // ==========================================================
    // Read path with forwarding
    function automatic logic [DATA_W-1:0] merge(
        input logic [DATA_W-1:0] base,
        input logic [ENT_W-1:0] ent,
        input logic ok,
        input logic [AW-1:0] a
    );
        logic [DATA_W-1:0] r;
        r = base;
        if (ok && ent[ENT_W-1 -: AW] == a)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (ent[DATA_W + i])
                    r[i*LANE_W +: LANE_W] = ent[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction : merge

    logic [DATA_W-1:0] fresh;
    logic [DATA_W-1:0] stage_q;
    logic [DATA_W-1:0] stage_d;
    logic stage_v_q;
    logic stage_v_d;
    logic [DATA_W-1:0] data_out_d;
    logic data_oe_n_d;
    logic drive;

    always_comb
    begin
        // pending writes override array, oldest first
        fresh = merge(mem[acc_addr], wb.ent_data[0], wb.ent_valid[0],
                      acc_addr);
        fresh = merge(fresh, wb.ent_data[1], wb.ent_valid[1], acc_addr);
        stage_d = rd_now ? fresh : stage_q;
        stage_v_d = rd_now;
        if (pipeline_sel)
        begin
            data_out_d = stage_q;
            drive = stage_v_q;
        end
        else
        begin
            data_out_d = fresh;
            drive = rd_now;
        end
        // deselect tristates at once; output enable gates
        if (cyc == SBSC_DESELECT || wr_now)
            data_oe_n_d = 1'b1;
        else
            data_oe_n_d = !(drive && !output_enable_n);
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stage_q <= DATA_ZERO;
            stage_v_q <= 1'b0;
            data_out <= DATA_ZERO;
            data_oe_n <= 1'b1;
        end
        else
        begin
            stage_q <= stage_d;
            stage_v_q <= stage_v_d;
            data_out <= data_out_d;
            data_oe_n <= data_oe_n_d;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    desel_tristate_a: assert property (
        cyc == SBSC_DESELECT |=> data_oe_n)
        else $error("deselect did not tristate data");
    select_decode_a: assert property (
        (load && second_select_n) |-> cyc == SBSC_DESELECT)
        else $error("inactive second select not deselected");
    oe_gate_a: assert property (
        output_enable_n |=> data_oe_n)
        else $error("data driven with output enable high");
    proc_read_a: assert property (
        (all_sel && !proc_addr_strobe_n && !any_lane_write_n)
        |-> cyc == SBSC_BEGIN_RD && !wb.in_valid)
        else $error("processor start did not read");
    ctrl_write_a: assert property (
        (all_sel && proc_addr_strobe_n && !ctrl_addr_strobe_n)
        |-> (cyc == SBSC_BEGIN_WR) == (lane_n != LANES_OFF))
        else $error("controller start wrong direction");
    lane_mask_a: assert property (
        wb.in_valid |-> wb.in_data[DATA_W +: LANES] == ~lane_n)
        else $error("write lane mask wrong");
    cont_step_a: assert property (
        cyc == SBSC_CONT |=> cnt_q == $past(cnt_q) + CNT_STEP)
        else $error("continue did not step counter");
    susp_hold_a: assert property (
        cyc == SBSC_SUSP |=> cnt_q == $past(cnt_q) && $stable(base_q))
        else $error("suspend moved burst address");
    order_a: assert property (
        burst_order_sel |-> (acc_addr ^ base_d) == {{(AW-CNT_W){1'b0}}, cnt_d})
        else $error("interleaved order wrong");
    flow_drive_a: assert property (
        (!pipeline_sel && rd_now && !output_enable_n)
        |=> !data_oe_n && data_out == $past(fresh))
        else $error("flow-through data late");
    pipe_drive_a: assert property (
        (pipeline_sel && rd_now && !output_enable_n) ##1
        (pipeline_sel && rd_now && !output_enable_n)
        |=> !data_oe_n && data_out == $past(fresh, 2))
        else $error("pipelined data not one stage later");
    fwd_a: assert property (
        (wb.ent_valid[0] && wb.ent_data[0][ENT_W-1 -: AW] == acc_addr &&
         wb.ent_data[0][DATA_W +: LANES] == ~LANES_OFF && !wb.ent_valid[1])
        |-> fresh == wb.ent_data[0][DATA_W-1:0])
        else $error("pending write not forwarded");
    no_drop_a: assert property (
        wr_now |-> wb.in_ready)
        else $error("write word lost");

    begin_rd_c: cover property (cyc == SBSC_BEGIN_RD ##1
                                cyc == SBSC_CONT);
    begin_wr_c: cover property (cyc == SBSC_BEGIN_WR ##1
                                cyc == SBSC_SUSP);
    rd_after_wr_c: cover property (wr_now ##1 rd_now && wb.ent_valid[0]);
    buf_full_c: cover property (wb.ent_valid == 2'h3);
endmodule : sbsc_top

// ---- sim/sbsc_ctrl_model.sv ----
// Bus master model presenting one SRAM cycle per call
`timescale 1ns/1ps
module sbsc_ctrl_model (
    output logic [10:0] ctl,
    output logic [14:0] addr,
    output logic [31:0] wdata
);
    // ==========================================
    // Idle state: deselected, output enable off
    initial
    begin
        ctl = 11'h6DF;
        addr = 15'h0;
        wdata = 32'h0000_0000;
    end

    // ==========================================
    // Cycle driver
    // called just after an edge, held to next
    task automatic put(input logic [10:0] c, input logic [14:0] a,
                       input logic [31:0] d);
        addr = a;
        ctl = (c[3:0] != 4'hF && c[6]) ? (c | 11'h400) : c;
        // Released bus toggles so stale data never passes
        wdata = (ctl[3:0] != 4'hF) ? d : ~wdata;
    endtask : put
endmodule : sbsc_ctrl_model

// ---- sim/sbsc_top_test.sv ----
// Self-checking bench for the burst SRAM cycle control
`timescale 1ns/1ps
module sbsc_top_test;
    import sbsc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ord = 1'b0;
    logic pipe = 1'b0;
    logic [10:0] ctl;
    logic [14:0] addr;
    logic [31:0] wdata;
    logic [31:0] data_out;
    logic data_oe_n;
    int n_errors = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h861F;
    logic [31:0] mem [int];
    logic [14:0] a = 15'h0;
    logic [14:0] base = 15'h0;
    logic [1:0] cnt = 2'h0;
    logic exp_oe_n = 1'b1;
    logic [31:0] exp_d = 32'h0;
    logic prv_rd = 1'b0;
    logic [31:0] prv_d = 32'h0;
    logic [10:0] dsl [5] = '{11'h6DF, 11'h1BF, 11'h03F, 11'h1DF, 11'h05F};

    always #5 clk = ~clk;

    sbsc_ctrl_model u_ctrl (.ctl(ctl), .addr(addr), .wdata(wdata));

    sbsc_top u_dut (
        .clk(clk), .resetn(resetn), .addr(addr),
        .chip_select_n(ctl[9]), .second_select_hi(ctl[8]),
        .second_select_n(ctl[7]), .proc_addr_strobe_n(ctl[6]),
        .ctrl_addr_strobe_n(ctl[5]), .burst_step_n(ctl[4]),
        .lane0_write_n(ctl[0]), .lane1_write_n(ctl[1]),
        .lane2_write_n(ctl[2]), .lane3_write_n(ctl[3]),
        .output_enable_n(ctl[10]), .burst_order_sel(ord),
        .pipeline_sel(pipe), .data_in(wdata),
        .data_out(data_out), .data_oe_n(data_oe_n)
    );

    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    // ==========================================
    // One bus cycle: check last answer, drive, predict
    task automatic cyc(input logic [10:0] c);
        logic desel;
        logic wr;
        logic rd;
        logic [14:0] ad;
        logic [31:0] d;
        logic [31:0] m;
        @(posedge clk);
        #1;
        check("data_oe_n", {31'h0, data_oe_n}, {31'h0, exp_oe_n});
        if (exp_oe_n === 1'b0)
            check("data_out", data_out, exp_d);
        d = rnd();
        u_ctrl.put(c, a, d);
        c = u_ctrl.ctl;
        desel = (c[9] && !c[5]) ||
                (!c[9] && !(c[6] && c[5]) && !(c[8] && !c[7]));
        if (!desel && !c[9] && (!c[6] || !c[5]))
        begin
            base = a;
            cnt = 2'h0;
            wr = c[6] && c[3:0] != 4'hF;
        end
        else
        begin
            cnt = cnt + {1'b0, ~c[4] & ~desel};
            wr = !desel && c[3:0] != 4'hF;
        end
        ad = {base[14:2], ord ? base[1:0] ^ cnt : base[1:0] + cnt};
        rd = !desel && !wr;
        m = mem.exists(ad) ? mem[ad] : DATA_ZERO;
        if (wr)
        begin
            for (int i = 0; i < 4; i++)
                if (!c[i])
                    m[8*i +: 8] = d[8*i +: 8];
            mem[ad] = m;
        end
        exp_d = pipe ? prv_d : m;
        exp_oe_n = pipe ? !(rd && prv_rd && !c[10]) : !(rd && !c[10]);
        prv_rd = rd;
        prv_d = m;
    endtask : cyc

    // ==========================================
    // Watchdog
    initial
    begin
        #200000;
        n_errors++;
        conclude();
    end

    // ==========================================
    // Main sequence over all four order and pipeline modes
    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            cyc(11'h6DF);
            {pipe, ord} = k[1:0];
            a = 15'(rnd());
            cyc(11'h150);
            cyc(11'h2E0);
            cyc(11'h2F0);
            cyc(11'h160);
            cyc(11'h2E0);
            cyc(11'h13F);
            cyc(11'h2EF);
            cyc(11'h2FF);
            cyc(11'h16F);
            cyc(11'h2EF);
            if (!pipe)
                cyc(11'h6FF);
            for (int j = 0; j < 5; j++)
            begin
                cyc(11'h13F);
                cyc(dsl[j]);
            end
            cyc(11'h15F);
            cyc(11'h130);
            cyc(11'h2F0 | {7'h0, seed[3:1], 1'b0});
            cyc(11'h15F);
            cyc(11'h2FF);
            cyc(11'h6DF);
        end
        cyc(11'h6DF);
        conclude();
    end
endmodule : sbsc_top_test
